// File: eac_pkg.sv
package eac_pkg;
    // ----------------------------------------------------------------
    // record byte offsets of identity fields and reserved area
    // ----------------------------------------------------------------
    localparam int PROD_OFS   = 256;
    localparam int SVN_OFS    = 258;
    localparam int CFGSVN_OFS = 260;
    localparam int RSV_OFS    = 262;
    localparam int RSV_LEN    = 3834;
    localparam int SVN_LSB    = (SVN_OFS - PROD_OFS) * 8;
    localparam int RSVB_LSB   = (RSV_OFS - CFGSVN_OFS) * 8;

    // ----------------------------------------------------------------
    // apb byte addresses
    // ----------------------------------------------------------------
    localparam logic [11:0] A_MISC  = 12'h010;
    localparam logic [11:0] A_FLOW  = 12'h020;
    localparam logic [11:0] A_ATTR  = 12'h030;
    localparam logic [11:0] A_IDS   = 12'(PROD_OFS);
    localparam logic [11:0] A_CFG   = 12'(CFGSVN_OFS);
    localparam logic [11:0] A_RSV   = 12'h108;
    localparam logic [11:0] A_CTRL  = 12'h200;
    localparam logic [11:0] A_STAT  = 12'h204;
    localparam logic [11:0] A_PERM  = 12'h208;
    localparam logic [11:0] A_CAPM  = 12'h20C;
    localparam logic [11:0] A_MSIZE = 12'h210;
    localparam int          ATTR_WORDS = 4;
    localparam int          RSV_WORDS  = 10;
    localparam int          EID_WORDS  = 2;

    // ----------------------------------------------------------------
    // attribute, selection and flow bit fields
    // ----------------------------------------------------------------
    localparam int B_INIT  = 0;
    localparam int B_DEBUG = 1;
    localparam int B_WIDE  = 2;
    localparam int B_PROV  = 4;
    localparam int B_TOKEN = 5;
    localparam int B_FLOW  = 6;
    localparam int B_KSEP  = 7;
    localparam logic [63:0] ATTR_RSV = 64'hFFFF_FFFF_FFFF_FF08;
    localparam int M_FAULT = 0;
    localparam int M_PROT  = 1;
    localparam logic [31:0] MISC_RSV = 32'hFFFF_FFFC;
    localparam logic [7:0]  FLOW_RSV = 8'hC0;
    localparam logic [7:0]  FLOW_SS  = 8'h03;
    localparam logic [7:0]  FLOW_IBT = 8'h3C;
    localparam logic [7:0]  FAULT_INFO_BYTES = 8'h10;
    localparam logic [7:0]  PROT_INFO_BYTES  = 8'h10;

    // ----------------------------------------------------------------
    // control bits and reset values
    // ----------------------------------------------------------------
    localparam int C_CREATE = 0;
    localparam int C_INIT   = 1;
    localparam int C_CLEAR  = 2;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [63:0] EID_RST  = 64'h0000_0000_0000_0001;

    typedef enum logic [1:0] {EAC_IDLE, EAC_BUILT, EAC_READY} eac_state_t;
endpackage

// File: eac_checker.sv
`timescale 1ns/1ps
module eac_checker (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [127:0] cap_attr,
    input  wire logic [31:0]  cap_misc,
    input  wire logic         cap_shadow,
    input  wire logic         cap_branch,
    output logic              enclave_initialized,
    output logic              debug_access_ok,
    output logic              provisioning_key_allow,
    output logic              token_key_allow,
    output logic              wide_mode_flag,
    output logic              key_separation_enable,
    output logic [63:0]       feature_request_mask,
    output logic              fault_info_select,
    output logic              protection_fault_info_select,
    output logic [7:0]        misc_size,
    output logic              shadow_stack_enable,
    output logic              shadow_write_enable,
    output logic              branch_tracking_enable,
    output logic              legacy_compat_enable,
    output logic              no_track_enable,
    output logic              suppression_disable
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    eac_pkg::eac_state_t st_q;
    logic [31:0]         attr_q [eac_pkg::ATTR_WORDS];
    logic [31:0]         rsv_q  [eac_pkg::RSV_WORDS];
    logic [31:0]         misc_q;
    logic [7:0]          flow_q;
    logic [31:0]         ids_q;
    logic [31:0]         cfg_q;
    logic [63:0]         eid_q;
    logic                fault_q;
    logic [5:0]          cause_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic [31:0]         rd_data;
    logic                hit;
    logic                rec_addr;
    logic                ro_addr;
    logic [9:0]          rsv_idx;
    logic [9:0]          attr_idx;
    logic                wr_go;
    logic                rec_wr;
    logic                create_go;
    logic                init_go;
    logic                clear_go;
    logic [63:0]         attr_lo;
    logic [127:0]        attr_all;
    logic                bad_rsv_attr;
    logic                bad_cap_attr;
    logic                bad_init;
    logic                bad_misc;
    logic                bad_flow;
    logic                bad_area;
    logic [5:0]          cause;
    logic [7:0]          msize;

    assign attr_lo  = {attr_q[1], attr_q[0]};
    assign attr_all = {attr_q[3], attr_q[2], attr_lo};
    assign rsv_idx  = paddr[11:2] - eac_pkg::A_RSV[11:2];
    assign attr_idx = paddr[11:2] - eac_pkg::A_ATTR[11:2];

    // ----------------------------------------------------------------
    // address decode and read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_data  = eac_pkg::WORD_RST;
        hit      = 1'b1;
        rec_addr = 1'b1;
        ro_addr  = 1'b0;
        if (attr_idx < 10'(eac_pkg::ATTR_WORDS)) begin
            rd_data = attr_q[attr_idx[1:0]];
        end else if (rsv_idx < 10'(eac_pkg::RSV_WORDS)) begin
            rd_data = rsv_q[rsv_idx[3:0]];
            ro_addr = rsv_idx < 10'(eac_pkg::EID_WORDS);
        end else begin
            unique case (paddr)
                eac_pkg::A_MISC: rd_data = misc_q;
                eac_pkg::A_FLOW: rd_data = {24'h00_0000, flow_q};
                eac_pkg::A_IDS:  rd_data = ids_q;
                eac_pkg::A_CFG:  rd_data = cfg_q;
                eac_pkg::A_CTRL: rec_addr = 1'b0;
                eac_pkg::A_STAT: begin
                    rec_addr = 1'b0;
                    ro_addr  = 1'b1;
                    rd_data  = {18'h0_0000, cause_q, 5'h00,
                                fault_q, st_q == eac_pkg::EAC_READY,
                                st_q != eac_pkg::EAC_IDLE};
                end
                eac_pkg::A_PERM: begin
                    rec_addr = 1'b0;
                    ro_addr  = 1'b1;
                    rd_data  = {26'h000_0000, key_separation_enable,
                                wide_mode_flag, token_key_allow,
                                provisioning_key_allow, debug_access_ok,
                                enclave_initialized};
                end
                eac_pkg::A_CAPM: begin
                    rec_addr = 1'b0;
                    ro_addr  = 1'b1;
                    rd_data  = cap_misc;
                end
                eac_pkg::A_MSIZE: begin
                    rec_addr = 1'b0;
                    ro_addr  = 1'b1;
                    rd_data  = {24'h00_0000, misc_size};
                end
                default: begin
                    hit      = 1'b0;
                    rec_addr = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // apb slave, one wait state
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= eac_pkg::WORD_RST;
        end else if (psel && penable && !pready_q) begin
            pready_q  <= 1'b1;
            prdata_q  <= pwrite ? eac_pkg::WORD_RST : rd_data;
            pslverr_q <= !hit || (pwrite && ro_addr) ||
                         (pwrite && rec_addr && st_q != eac_pkg::EAC_IDLE);
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    assign wr_go     = psel && penable && pwrite && pready_q && !pslverr_q;
    assign rec_wr    = wr_go && rec_addr;
    assign create_go = wr_go && paddr == eac_pkg::A_CTRL &&
                       pwdata[eac_pkg::C_CREATE] &&
                       st_q == eac_pkg::EAC_IDLE;
    assign init_go   = wr_go && paddr == eac_pkg::A_CTRL &&
                       pwdata[eac_pkg::C_INIT] &&
                       st_q == eac_pkg::EAC_BUILT;
    assign clear_go  = wr_go && paddr == eac_pkg::A_CTRL &&
                       pwdata[eac_pkg::C_CLEAR];

    // ----------------------------------------------------------------
    // record checks at create
    // ----------------------------------------------------------------
    // reserved attribute bits
    assign bad_rsv_attr = |(attr_lo & eac_pkg::ATTR_RSV) ||
                          (attr_lo[eac_pkg::B_FLOW] && !cap_attr[6]);
    assign bad_cap_attr = |(attr_all & ~cap_attr);
    assign bad_init     = attr_lo[eac_pkg::B_INIT];
    assign bad_misc = (cap_misc == 32'h0000_0000 && misc_q != 32'h0000_0000)
                   || |(misc_q & eac_pkg::MISC_RSV)
                   || (misc_q[eac_pkg::M_PROT] && !cap_misc[1])
                   || |(misc_q & ~cap_misc);
    assign bad_flow = |(flow_q & eac_pkg::FLOW_RSV)
                   || (|(flow_q & eac_pkg::FLOW_SS) && !cap_shadow)
                   || (|(flow_q & eac_pkg::FLOW_IBT) && !cap_branch)
                   || (flow_q != 8'h00 && !attr_lo[eac_pkg::B_FLOW]);
    assign bad_area = cfg_q[31:eac_pkg::RSVB_LSB] != 16'h0000;
    assign cause    = {bad_area, bad_flow, bad_misc, bad_init,
                       bad_cap_attr, bad_rsv_attr};

    // ----------------------------------------------------------------
    // lifecycle state and fault status
    // ----------------------------------------------------------------
    // reject create on any fault
    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q    <= eac_pkg::EAC_IDLE;
            fault_q <= 1'b0;
            cause_q <= 6'h00;
        end else if (clear_go) begin
            st_q    <= eac_pkg::EAC_IDLE;
            fault_q <= 1'b0;
            cause_q <= 6'h00;
        end else if (create_go) begin
            fault_q <= cause != 6'h00;
            cause_q <= cause;
            if (cause == 6'h00) begin
                st_q <= eac_pkg::EAC_BUILT;
            end
        end else if (init_go) begin
            st_q <= eac_pkg::EAC_READY;
        end
    end

    // ----------------------------------------------------------------
    // record fields written by software
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < eac_pkg::ATTR_WORDS; i++) begin
                attr_q[i] <= eac_pkg::WORD_RST;
            end
        end else begin
            if (rec_wr && attr_idx < 10'(eac_pkg::ATTR_WORDS)) begin
                attr_q[attr_idx[1:0]] <= pwdata;
            end
            if (clear_go) begin
                attr_q[0][eac_pkg::B_INIT] <= 1'b0;
            end else if (init_go) begin
                attr_q[0][eac_pkg::B_INIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            misc_q <= eac_pkg::WORD_RST;
            flow_q <= 8'h00;
            ids_q  <= eac_pkg::WORD_RST;
            cfg_q  <= eac_pkg::WORD_RST;
        end else if (rec_wr) begin
            unique case (paddr)
                eac_pkg::A_MISC: misc_q <= pwdata;
                eac_pkg::A_FLOW: flow_q <= pwdata[7:0];
                eac_pkg::A_IDS:  ids_q  <= pwdata;
                eac_pkg::A_CFG:  cfg_q  <= pwdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // reserved area words: identifier, family and extended ids
    // ----------------------------------------------------------------
    // identifier taken from a running count
    always_ff @(posedge clock) begin
        if (!nrst) begin
            eid_q <= eac_pkg::EID_RST;
        end else if (create_go && cause == 6'h00) begin
            eid_q <= eid_q + 64'h0000_0000_0000_0001;
        end
    end

    genvar g;
    generate
        for (g = 0; g < eac_pkg::RSV_WORDS; g++) begin : g_rsv
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    rsv_q[g] <= eac_pkg::WORD_RST;
                end else if (g < eac_pkg::EID_WORDS) begin
                    if (create_go && cause == 6'h00) begin
                        rsv_q[g] <= eid_q[32*(g%2) +: 32];
                    end
                end else if (rec_wr && rsv_idx == 10'(g)) begin
                    rsv_q[g] <= pwdata;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // registered permissions and decoded controls
    // ----------------------------------------------------------------
    // exit info region size
    assign msize = (misc_q[eac_pkg::M_FAULT] ?
                    eac_pkg::FAULT_INFO_BYTES : 8'h00) +
                   (misc_q[eac_pkg::M_PROT] ?
                    eac_pkg::PROT_INFO_BYTES : 8'h00);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            enclave_initialized          <= 1'b0;
            debug_access_ok              <= 1'b0;
            provisioning_key_allow       <= 1'b0;
            token_key_allow              <= 1'b0;
            wide_mode_flag               <= 1'b0;
            key_separation_enable        <= 1'b0;
            feature_request_mask         <= 64'h0;
            fault_info_select            <= 1'b0;
            protection_fault_info_select <= 1'b0;
            misc_size                    <= 8'h00;
            shadow_stack_enable          <= 1'b0;
            shadow_write_enable          <= 1'b0;
            branch_tracking_enable       <= 1'b0;
            legacy_compat_enable         <= 1'b0;
            no_track_enable              <= 1'b0;
            suppression_disable          <= 1'b0;
        end else begin
            enclave_initialized <= st_q == eac_pkg::EAC_READY &&
                                   attr_lo[eac_pkg::B_INIT];
            debug_access_ok <= st_q != eac_pkg::EAC_IDLE &&
                               attr_lo[eac_pkg::B_DEBUG];
            provisioning_key_allow <= st_q == eac_pkg::EAC_READY &&
                                      attr_lo[eac_pkg::B_PROV];
            token_key_allow <= st_q == eac_pkg::EAC_READY &&
                               attr_lo[eac_pkg::B_TOKEN];
            wide_mode_flag <= st_q != eac_pkg::EAC_IDLE &&
                              attr_lo[eac_pkg::B_WIDE];
            key_separation_enable <= st_q != eac_pkg::EAC_IDLE &&
                                     attr_lo[eac_pkg::B_KSEP];
            feature_request_mask <= st_q != eac_pkg::EAC_IDLE ?
                                    attr_all[127:64] : 64'h0;
            fault_info_select <= st_q != eac_pkg::EAC_IDLE &&
                                 misc_q[eac_pkg::M_FAULT];
            protection_fault_info_select <= st_q != eac_pkg::EAC_IDLE &&
                                            misc_q[eac_pkg::M_PROT];
            misc_size <= st_q != eac_pkg::EAC_IDLE ? msize : 8'h00;
            shadow_stack_enable <= st_q != eac_pkg::EAC_IDLE && flow_q[0];
            shadow_write_enable <= st_q != eac_pkg::EAC_IDLE && flow_q[1];
            branch_tracking_enable <= st_q != eac_pkg::EAC_IDLE && flow_q[2];
            legacy_compat_enable   <= st_q != eac_pkg::EAC_IDLE && flow_q[3];
            no_track_enable        <= st_q != eac_pkg::EAC_IDLE && flow_q[4];
            suppression_disable    <= st_q != eac_pkg::EAC_IDLE && flow_q[5];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_create_req;
        create_go;
    endsequence
    sequence s_built;
        st_q == eac_pkg::EAC_BUILT;
    endsequence

    property p_init_set;
        init_go |=> st_q == eac_pkg::EAC_READY ##1 enclave_initialized;
    endproperty
    a_init_set: assert property (p_init_set)
        else $error("init did not mark enclave initialized");

    property p_init_reject;
        s_create_req and attr_lo[0] |=> fault_q && cause_q[2] &&
                                        st_q == eac_pkg::EAC_IDLE;
    endproperty
    a_init_reject: assert property (p_init_reject)
        else $error("create with init bit set was accepted");

    property p_rsv_attr;
        s_create_req and |(attr_lo & eac_pkg::ATTR_RSV) |=> fault_q;
    endproperty
    a_rsv_attr: assert property (p_rsv_attr)
        else $error("reserved attribute bit accepted");

    property p_cap_attr;
        s_create_req and |(attr_all & ~cap_attr) |=> fault_q && cause_q[1] &&
                                                     st_q == eac_pkg::EAC_IDLE;
    endproperty
    a_cap_attr: assert property (p_cap_attr)
        else $error("attribute without capability accepted");

    property p_flow_cap;
        s_create_req and attr_lo[6] && !cap_attr[6] |=> cause_q[0];
    endproperty
    a_flow_cap: assert property (p_flow_cap)
        else $error("flow attribute bit accepted without capability");

    property p_misc_zero;
        s_create_req and cap_misc == 32'h0 && misc_q != 32'h0
            |=> fault_q && cause_q[3];
    endproperty
    a_misc_zero: assert property (p_misc_zero)
        else $error("selection accepted with zero capability");

    property p_debug;
        debug_access_ok |-> $past(attr_lo[1]) &&
                            $past(st_q) != eac_pkg::EAC_IDLE;
    endproperty
    a_debug: assert property (p_debug)
        else $error("debug access without debug attribute");

    property p_prov;
        provisioning_key_allow |-> $past(attr_lo[4]) &&
                                   $past(st_q) == eac_pkg::EAC_READY;
    endproperty
    a_prov: assert property (p_prov)
        else $error("provisioning key released without attribute");

    sequence s_sized;
        st_q != eac_pkg::EAC_IDLE;
    endsequence
    property p_misc_size;
        s_built ##1 s_sized |=> misc_size ==
            ($past(misc_q[0]) ? eac_pkg::FAULT_INFO_BYTES : 8'h00) +
            ($past(misc_q[1]) ? eac_pkg::PROT_INFO_BYTES : 8'h00);
    endproperty
    a_misc_size: assert property (p_misc_size)
        else $error("exit info size does not follow selection");
endmodule

// File: eac_sw_model.sv
`timescale 1ns/1ps
module eac_sw_model (
    input  wire logic        clock,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // ------------------------------------------------------------
    // one apb transfer, held until pready is sampled high
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
    // ------------------------------------------------------------
    // record load before create
    // ------------------------------------------------------------
    task automatic rec(input logic [7:0] at, input logic [1:0] ms,
                       input logic [7:0] fl, input logic [63:0] xf);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, eac_pkg::A_MISC, {30'h0, ms}, r, e);
        xfer(1'b1, eac_pkg::A_FLOW, {24'h0, fl}, r, e);
        xfer(1'b1, eac_pkg::A_ATTR, {24'h0, at}, r, e);
        xfer(1'b1, 12'h034, 32'h0000_0000, r, e);
        xfer(1'b1, 12'h038, xf[31:0], r, e);
        xfer(1'b1, 12'h03C, xf[63:32], r, e);
        xfer(1'b1, eac_pkg::A_CFG, 32'h0000_0000, r, e);
    endtask
endmodule

// File: eac_checker_tb.sv
`timescale 1ns/1ps
module eac_checker_tb;
    logic         clock, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, cap_misc, r;
    logic [127:0] cap_attr;
    logic         cap_shadow, cap_branch, e, p;
    logic         enclave_initialized, debug_access_ok, wide_mode_flag;
    logic         provisioning_key_allow, token_key_allow;
    logic         key_separation_enable, fault_info_select;
    logic         protection_fault_info_select, shadow_stack_enable;
    logic         shadow_write_enable, branch_tracking_enable;
    logic         legacy_compat_enable, no_track_enable;
    logic         suppression_disable;
    logic [63:0]  feature_request_mask, xf;
    logic [7:0]   misc_size, at, fl, sz;
    logic [1:0]   ms;
    int           n_mismatch, samples_checked, n_ok, seed_v;
    eac_sw_model u_sw (.clock, .pready, .pslverr, .prdata, .psel,
                       .penable, .pwrite, .paddr, .pwdata);
    eac_checker u_dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cap_attr, .cap_misc,
        .cap_shadow, .cap_branch, .enclave_initialized, .debug_access_ok,
        .provisioning_key_allow, .token_key_allow, .wide_mode_flag,
        .key_separation_enable, .feature_request_mask, .fault_info_select,
        .protection_fault_info_select, .misc_size, .shadow_stack_enable,
        .shadow_write_enable, .branch_tracking_enable,
        .legacy_compat_enable, .no_track_enable, .suppression_disable);
    initial clock = 1'b0;
    always #5 clock = ~clock;
    // reference model of the create-time checks
    function automatic logic ok_model();
        return !at[0] && !at[3] && (at & ~cap_attr[7:0]) == 8'h00
            && (ms & ~cap_misc[1:0]) == 2'h0 && fl[7:6] == 2'h0
            && (fl == 8'h00 || at[6]) && (fl[1:0] == 2'h0 || cap_shadow)
            && (fl[5:2] == 4'h0 || cap_branch);
    endfunction
    task automatic chk(input string nm, input logic [63:0] ex,
                       input logic [63:0] got);
        samples_checked++;
        if (got !== ex) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        finish_test();
    end
    initial begin
        nrst = 1'b0;
        cap_attr = '0;
        cap_misc = '0;
        cap_shadow = 1'b0;
        cap_branch = 1'b0;
        seed_v = $urandom(32'hD39F8338);
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        u_sw.xfer(1'b0, eac_pkg::A_STAT, 32'h0, r, e);
        chk("stat_rst", 64'h0, r);
        u_sw.xfer(1'b0, 12'h300, 32'h0, r, e);
        chk("unmapped", 64'h1_0000_0000, {e, r});
        u_sw.xfer(1'b1, eac_pkg::A_STAT, 32'h1, r, e);
        chk("ro_write_err", 64'h1, e);
        u_sw.xfer(1'b1, eac_pkg::A_IDS, 32'hA5C3_1E07, r, e);
        u_sw.xfer(1'b0, eac_pkg::A_IDS, 32'h0, r, e);
        chk("ids", 64'hA5C3_1E07, r);
        u_sw.xfer(1'b1, 12'h110, 32'h5A3C_96E1, r, e);
        u_sw.xfer(1'b0, 12'h110, 32'h0, r, e);
        chk("family_id", 64'h5A3C_96E1, r);
        u_sw.xfer(1'b1, 12'h108, 32'h1, r, e);
        chk("ident_ro", 64'h1, e);
        for (int i = 0; i < 40; i++) begin
            cap_attr <= {{64{1'b1}}, 56'h0, 8'($urandom) | 8'hB7};
            cap_misc <= $urandom & 32'h0000_0003;
            cap_shadow <= 1'($urandom);
            cap_branch <= 1'($urandom);
            at = 8'($urandom) & 8'hF6;
            if ($urandom % 6 == 0) at ^= 8'h09;
            ms = 2'($urandom);
            fl = ($urandom % 2) ? 8'($urandom) & 8'h3F : 8'h00;
            if ($urandom % 8 == 0) fl |= 8'h40;
            xf = {$urandom, $urandom};
            u_sw.xfer(1'b1, eac_pkg::A_CTRL, 32'h4, r, e);
            u_sw.rec(at, ms, fl, xf);
            u_sw.xfer(1'b1, eac_pkg::A_CTRL, 32'h1, r, e);
            p = ok_model();
            n_ok += int'(p);
            repeat (2) @(posedge clock);
            u_sw.xfer(1'b0, eac_pkg::A_STAT, 32'h0, r, e);
            chk("built_fault", {p, !p},
                {r[0], r[2]});
            if (p) begin
                sz = 8'(16 * (int'(ms[0]) + int'(ms[1])));
                chk("misc_size", sz, misc_size);
                u_sw.xfer(1'b0, eac_pkg::A_MSIZE, 32'h0, r, e);
                chk("msize_reg", sz, r);
                u_sw.xfer(1'b0, eac_pkg::A_CAPM, 32'h0, r, e);
                chk("capm", cap_misc, r);
                chk("flow", fl[5:0], {suppression_disable, no_track_enable,
                    legacy_compat_enable, branch_tracking_enable,
                    shadow_write_enable, shadow_stack_enable});
                chk("feature_request_mask", xf, feature_request_mask);
                chk("sel", ms, {protection_fault_info_select,
                    fault_info_select});
                chk("built", {at[7], at[2], at[1], 1'b0},
                    {key_separation_enable, wide_mode_flag, debug_access_ok,
                    provisioning_key_allow});
                u_sw.xfer(1'b0, 12'h108, 32'h0, r, e);
                chk("ident", 64'(n_ok), r);
                u_sw.xfer(1'b1, eac_pkg::A_ATTR, 32'h0, r, e);
                chk("locked", 64'h1, e);
                u_sw.xfer(1'b1, eac_pkg::A_CTRL, 32'h2, r, e);
                repeat (2) @(posedge clock);
                u_sw.xfer(1'b0, eac_pkg::A_PERM, 32'h0, r, e);
                chk("perm", {at[7], at[2], at[5], at[4], at[1], 1'b1},
                    r);
                chk("init", {at[5], at[4], 1'b1}, {token_key_allow,
                    provisioning_key_allow, enclave_initialized});
                u_sw.xfer(1'b0, eac_pkg::A_ATTR, 32'h0, r, e);
                chk("report_init", {at[7:1], 1'b1}, r);
            end
        end
        finish_test();
    end
endmodule
